// >>> design/event_flag.v
// sticky event flag: hardware sets, software clears by writing one
`timescale 1ns/100ps
module event_flag (
    input wire i_clk,
    input wire i_rst,
    input wire i_set,
    input wire i_clr,
    output reg o_flag
);
    // set beats clear so an event in the clearing cycle is not lost
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule // event_flag

// >>> design/t1_slc96_sf_frame_monitor.v
// t1 receive framer: slc-96 / sf alignment search, in-frame monitoring, axi4-lite registers
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "t1_frame_monitor_regs.vh"
module t1_slc96_sf_frame_monitor #(
    parameter ERRCNT_W = 16
) (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_LINE_BIT,
    input wire I_LINE_VALID,
    input wire [7:0] I_S_AXI_AWADDR,
    input wire I_S_AXI_AWVALID,
    output reg O_S_AXI_AWREADY,
    input wire [31:0] I_S_AXI_WDATA,
    input wire [3:0] I_S_AXI_WSTRB,
    input wire I_S_AXI_WVALID,
    output reg O_S_AXI_WREADY,
    output reg [1:0] O_S_AXI_BRESP,
    output reg O_S_AXI_BVALID,
    input wire I_S_AXI_BREADY,
    input wire [7:0] I_S_AXI_ARADDR,
    input wire I_S_AXI_ARVALID,
    output reg O_S_AXI_ARREADY,
    output reg [31:0] O_S_AXI_RDATA,
    output reg [1:0] O_S_AXI_RRESP,
    output reg O_S_AXI_RVALID,
    input wire I_S_AXI_RREADY,
    output reg O_OUT_OF_FRAME,
    output reg [6:0] O_FRAME_NUM,
    output reg O_FBIT_STROBE,
    output reg O_MF_START,
    output reg O_SIG_BIT,
    output reg [1:0] O_SIG_PHASE,
    output reg O_PM_FBIT_ERR,
    output reg O_PM_COFA
);
    // software state
    reg [4:0] ctrl;
    reg manual_reframe_req_d;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [ERRCNT_W-1:0] err_cnt;
    // framer state
    reg [23:0] hist [0:192];
    reg [7:0] raw_phase;
    reg [7:0] bit_cnt;
    reg [2:0] chan_bit;
    reg in_frame;
    reg lof;
    reg [4:0] srch_frames;
    reg [6:0] frame_num;
    reg [3:0] sf_pos;
    reg [2:0] sig_cnt;
    reg [1:0] sig_phase;
    reg sig_frame;
    reg [2:0] ft_win;
    reg [1:0] ft_errs;
    reg [3:0] lw_idx;
    reg [3:0] lw_len;
    reg [3:0] loss_errs;
    reg [7:0] prev_phase;
    reg have_prev;
    wire mfb_flag;
    wire sfe_flag;
    wire fbe_flag;
    wire cofa_flag;

    wire auto_en = ctrl[`CTRL_AUTO_BIT];
    wire [1:0] loss_threshold_sel = ctrl[`CTRL_LOSS_LSB+1:`CTRL_LOSS_LSB];
    wire slc = ctrl[`CTRL_SLC_BIT];
    wire manual_rise = ctrl[`CTRL_MANUAL_REFRAME_REQ_BIT] & ~manual_reframe_req_d;

    // parallel search: one f-bit history per candidate bit position
    wire [23:0] hist_now = hist[raw_phase];
    wire [23:0] hist_new = {hist_now[22:0], I_LINE_BIT};
    wire pat_match = slc ? (hist_new == `SLC_PATTERN) : (hist_new[11:0] == `SF_PATTERN);
    wire [4:0] pat_len = slc ? `SLC_PAT_LEN : `SF_PAT_LEN;
    // stale history would let a reframe lock at once, so a fresh pattern length is awaited
    wire search_ready = (srch_frames >= pat_len);
    wire sync_hit = I_LINE_VALID & ~in_frame & search_ready & pat_match;

    // frame bookkeeping at the f-bit slot
    wire f_slot = I_LINE_VALID & in_frame & (bit_cnt == 8'h00);
    wire [6:0] last_frame = slc ? `SLC_FRAMES : `SF_FRAMES;
    wire [6:0] next_frame = (frame_num >= last_frame) ? 7'h01 : frame_num + 7'h01;
    wire [3:0] next_sf_pos = (sf_pos == `SF_POS_LAST) ? 4'h0 : sf_pos + 4'h1;
    wire [11:0] sf_expect = `SF_EXPECT;
    wire exp_bit = sf_expect[next_sf_pos];
    // slc overhead fs positions (24..70) carry no alignment and are not checked
    wire check_en = next_frame[0] | ~slc | (next_frame <= `SLC_FS_LAST_CHECKED)
        | (next_frame == `SLC_FRAMES);
    wire fbit_err = f_slot & check_en & (I_LINE_BIT != exp_bit);
    wire ft_err = fbit_err & next_frame[0];
    wire mf_start = f_slot & (next_frame == 7'h01);
    wire [2:0] next_sig = (sig_cnt == `SIG_PERIOD) ? 3'h1 : sig_cnt + 3'h1;

    // severe ft window of six frames
    wire [1:0] ft_base = (ft_win == 3'h0) ? 2'h0 : ft_errs;
    wire severe_ft = ft_err & (ft_base != 2'h0);

    // loss window over checked f-bits, length chosen by the threshold field
    reg [3:0] sel_len;
    always @* begin
        case (loss_threshold_sel)
            2'h0: sel_len = `LOSS_WIN_0;
            2'h1: sel_len = `LOSS_WIN_1;
            2'h2: sel_len = `LOSS_WIN_2;
            2'h3: sel_len = `LOSS_WIN_3;
            default: sel_len = `LOSS_WIN_0;
        endcase
    end
    wire lw_start = (lw_idx == 4'h0);
    wire [3:0] lw_use = lw_start ? sel_len : lw_len;
    wire [3:0] lw_base = lw_start ? 4'h0 : loss_errs;
    wire [3:0] lw_sum = lw_base + {3'h0, fbit_err};
    wire loss = f_slot & check_en & (lw_sum > `LOSS_LIMIT);
    wire restart = manual_rise | (loss & auto_en);
    wire cofa = sync_hit & ~restart & have_prev & (raw_phase != prev_phase);

    // history memory has no reset; search_ready masks what it held
    always @(posedge I_CLK_SYS) begin
        if (I_LINE_VALID) begin
            hist[raw_phase] <= hist_new;
        end
    end

    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            raw_phase <= 8'h00;
            srch_frames <= 5'h00;
        end else begin
            if (I_LINE_VALID) begin
                raw_phase <= (raw_phase == `FRAME_LAST_BIT) ? 8'h00 : raw_phase + 8'h01;
            end
            if (restart) begin
                srch_frames <= 5'h00;
            end else if (I_LINE_VALID && raw_phase == `FRAME_LAST_BIT && !search_ready) begin
                srch_frames <= srch_frames + 5'h01;
            end
        end
    end

    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            in_frame <= 1'b0;
            lof <= 1'b0;
            bit_cnt <= 8'h00;
            chan_bit <= 3'h0;
            frame_num <= 7'h01;
            sf_pos <= 4'h0;
            sig_cnt <= 3'h0;
            sig_phase <= 2'h0;
            sig_frame <= 1'b0;
            ft_win <= 3'h0;
            ft_errs <= 2'h0;
            lw_idx <= 4'h0;
            lw_len <= `LOSS_WIN_0;
            loss_errs <= 4'h0;
            prev_phase <= 8'h00;
            have_prev <= 1'b0;
        end else if (restart) begin
            in_frame <= 1'b0;
            lof <= 1'b0;
        end else if (sync_hit) begin
            // the matching f-bit closes the pattern: frame 22 (slc) or 10 (sf)
            in_frame <= 1'b1;
            lof <= 1'b0;
            bit_cnt <= 8'h01;
            chan_bit <= 3'h0;
            frame_num <= slc ? `SLC_SYNC_FRAME : `SF_SYNC_FRAME;
            sf_pos <= `SYNC_SF_POS;
            sig_cnt <= `SYNC_SIG_CNT;
            sig_phase <= slc ? `SLC_SYNC_SIG_PHASE : `SF_SYNC_SIG_PHASE;
            sig_frame <= 1'b0;
            ft_win <= 3'h0;
            ft_errs <= 2'h0;
            lw_idx <= 4'h0;
            loss_errs <= 4'h0;
            prev_phase <= raw_phase;
            have_prev <= 1'b1;
        end else if (I_LINE_VALID && in_frame) begin
            bit_cnt <= (bit_cnt == `FRAME_LAST_BIT) ? 8'h00 : bit_cnt + 8'h01;
            chan_bit <= (bit_cnt == 8'h00) ? 3'h0 : chan_bit + 3'h1;
            if (bit_cnt == 8'h00) begin
                frame_num <= next_frame;
                sf_pos <= next_sf_pos;
                sig_cnt <= next_sig;
                sig_frame <= (next_sig == `SIG_PERIOD);
                if (next_sig == `SIG_PERIOD) begin
                    // sf only has a and b
                    sig_phase <= slc ? sig_phase + 2'h1 : {1'b0, ~sig_phase[0]};
                end
                ft_win <= (ft_win == `FT_WIN_LAST) ? 3'h0 : ft_win + 3'h1;
                ft_errs <= (ft_base == 2'h0) ? {1'b0, ft_err} : 2'h2;
                if (check_en) begin
                    if (lw_start) begin
                        lw_len <= sel_len;
                    end
                    lw_idx <= (lw_idx + 4'h1 >= lw_use) ? 4'h0 : lw_idx + 4'h1;
                    loss_errs <= lw_sum;
                    if (loss) begin
                        // auto reframe off: stay locked and keep reporting
                        lof <= 1'b1;
                        lw_idx <= 4'h0;
                    end
                end
            end
        end
    end

    // line-side outputs
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            manual_reframe_req_d <= 1'b0;
            O_OUT_OF_FRAME <= 1'b1;
            O_FRAME_NUM <= 7'h00;
            O_FBIT_STROBE <= 1'b0;
            O_MF_START <= 1'b0;
            O_SIG_BIT <= 1'b0;
            O_SIG_PHASE <= 2'h0;
            O_PM_FBIT_ERR <= 1'b0;
            O_PM_COFA <= 1'b0;
        end else begin
            manual_reframe_req_d <= ctrl[`CTRL_MANUAL_REFRAME_REQ_BIT];
            O_OUT_OF_FRAME <= ~in_frame;
            O_FRAME_NUM <= in_frame ? frame_num : 7'h00;
            O_FBIT_STROBE <= f_slot;
            O_MF_START <= mf_start & ~restart;
            O_SIG_BIT <= I_LINE_VALID & in_frame & ~restart & (bit_cnt != 8'h00)
                & (chan_bit == 3'h7) & sig_frame;
            if (f_slot && next_sig == `SIG_PERIOD) begin
                O_SIG_PHASE <= sig_phase;
            end
            O_PM_FBIT_ERR <= fbit_err & ~manual_rise;
            O_PM_COFA <= cofa;
        end
    end

    // axi4-lite write channel: address and data taken in either order
    wire wr_go = ~O_S_AXI_AWREADY & ~O_S_AXI_WREADY & ~O_S_AXI_BVALID;
    wire [5:0] wr_idx = aw_addr[7:2];
    wire wr_ctrl = wr_go & (wr_idx == `OFS_CTRL >> 2);
    wire wr_event = wr_go & (wr_idx == `OFS_EVENT >> 2);
    wire wr_errcnt = wr_go & (wr_idx == `OFS_ERRCNT >> 2);
    wire wr_ok = wr_ctrl | wr_event | wr_errcnt | (wr_idx == `OFS_STATUS >> 2);
    wire [3:0] ev_clr = (wr_event & w_strb[0]) ? w_data[3:0] : 4'h0;

    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_S_AXI_AWREADY <= 1'b1;
            O_S_AXI_WREADY <= 1'b1;
            O_S_AXI_BVALID <= 1'b0;
            O_S_AXI_BRESP <= `RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            ctrl <= `CTRL_RESET;
        end else begin
            if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
                aw_addr <= I_S_AXI_AWADDR;
                O_S_AXI_AWREADY <= 1'b0;
            end
            if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
                w_data <= I_S_AXI_WDATA;
                w_strb <= I_S_AXI_WSTRB;
                O_S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                O_S_AXI_BVALID <= 1'b1;
                O_S_AXI_BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_ctrl && w_strb[0]) begin
                    ctrl <= w_data[4:0];
                end
            end
            if (O_S_AXI_BVALID && I_S_AXI_BREADY) begin
                O_S_AXI_BVALID <= 1'b0;
                O_S_AXI_AWREADY <= 1'b1;
                O_S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // running f-bit error count; increments beat a clearing write
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            err_cnt <= {ERRCNT_W{1'b0}};
        end else if (fbit_err && !manual_rise) begin
            if (err_cnt != {ERRCNT_W{1'b1}}) begin
                err_cnt <= err_cnt + {{(ERRCNT_W-1){1'b0}}, 1'b1};
            end
        end else if (wr_errcnt) begin
            err_cnt <= {ERRCNT_W{1'b0}};
        end
    end

    // axi4-lite read channel, answer one cycle after the address is taken
    wire [5:0] rd_idx = I_S_AXI_ARADDR[7:2];
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (rd_idx)
            `OFS_CTRL >> 2: rd_mux[4:0] = ctrl;
            `OFS_STATUS >> 2: rd_mux = {8'h00, bit_cnt, 1'b0, frame_num, 6'h00, lof, ~in_frame};
            `OFS_EVENT >> 2: rd_mux[3:0] = {cofa_flag, fbe_flag, sfe_flag, mfb_flag};
            `OFS_ERRCNT >> 2: rd_mux[ERRCNT_W-1:0] = err_cnt;
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_S_AXI_ARREADY <= 1'b1;
            O_S_AXI_RVALID <= 1'b0;
            O_S_AXI_RDATA <= 32'h0000_0000;
            O_S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
                O_S_AXI_ARREADY <= 1'b0;
                O_S_AXI_RVALID <= 1'b1;
                O_S_AXI_RDATA <= rd_mux;
                O_S_AXI_RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (O_S_AXI_RVALID && I_S_AXI_RREADY) begin
                O_S_AXI_RVALID <= 1'b0;
                O_S_AXI_ARREADY <= 1'b1;
            end
        end
    end

    // sticky event flags
    event_flag u_mfb_flag (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_set(mf_start & ~restart),
        .i_clr(ev_clr[`EV_MFB_BIT]),
        .o_flag(mfb_flag)
    );
    event_flag u_sfe_flag (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_set(severe_ft & ~manual_rise),
        .i_clr(ev_clr[`EV_SFE_BIT]),
        .o_flag(sfe_flag)
    );
    event_flag u_fbe_flag (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_set(fbit_err & ~manual_rise),
        .i_clr(ev_clr[`EV_FBE_BIT]),
        .o_flag(fbe_flag)
    );
    event_flag u_cofa_flag (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_set(cofa),
        .i_clr(ev_clr[`EV_COFA_BIT]),
        .o_flag(cofa_flag)
    );
endmodule // t1_slc96_sf_frame_monitor

// >>> include/t1_frame_monitor_regs.vh
// register map, field positions, reset values and framing constants of the t1 frame monitor
`ifndef T1_FRAME_MONITOR_REGS_VH
`define T1_FRAME_MONITOR_REGS_VH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_EVENT 8'h08
`define OFS_ERRCNT 8'h0C
`define CTRL_AUTO_BIT 0
`define CTRL_MANUAL_REFRAME_REQ_BIT 1
`define CTRL_LOSS_LSB 2
`define CTRL_SLC_BIT 4
`define CTRL_RESET 5'h01
`define EV_MFB_BIT 0
`define EV_SFE_BIT 1
`define EV_FBE_BIT 2
`define EV_COFA_BIT 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FRAME_LAST_BIT 8'hC0
`define SLC_FRAMES 7'h48
`define SF_FRAMES 7'h0C
`define SLC_PATTERN 24'h23_7237
`define SF_PATTERN 12'h237
`define SLC_PAT_LEN 5'h18
`define SF_PAT_LEN 5'h0C
`define SF_EXPECT 12'h3B1
`define SLC_SYNC_FRAME 7'h16
`define SF_SYNC_FRAME 7'h0A
`define SYNC_SF_POS 4'h9
`define SF_POS_LAST 4'hB
`define SLC_FS_LAST_CHECKED 7'h16
`define SIG_PERIOD 3'h6
`define SYNC_SIG_CNT 3'h4
`define SLC_SYNC_SIG_PHASE 2'h3
`define SF_SYNC_SIG_PHASE 2'h1
`define FT_WIN_LAST 3'h5
`define LOSS_LIMIT 4'h1
`define LOSS_WIN_0 4'h4
`define LOSS_WIN_1 4'h5
`define LOSS_WIN_2 4'h6
`define LOSS_WIN_3 4'h8
`endif

// >>> test/t1_frame_monitor_assertions.sv
// port-level checks of the t1 frame monitor, bound to its top module
`timescale 1ns/100ps
module t1_frame_monitor_assertions (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_S_AXI_AWVALID,
    input wire O_S_AXI_AWREADY,
    input wire I_S_AXI_WVALID,
    input wire O_S_AXI_WREADY,
    input wire O_S_AXI_BVALID,
    input wire I_S_AXI_ARVALID,
    input wire O_S_AXI_ARREADY,
    input wire O_S_AXI_RVALID,
    input wire O_OUT_OF_FRAME,
    input wire [6:0] O_FRAME_NUM,
    input wire O_MF_START,
    input wire O_PM_FBIT_ERR,
    input wire O_PM_COFA
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);
    sequence s_wr_taken;
        I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY;
    endsequence
    // two cycles so the one-cycle output lag at lock and loss is never judged
    sequence s_oof_held;
        O_OUT_OF_FRAME ##1 O_OUT_OF_FRAME;
    endsequence
    sequence s_lock_held;
        !O_OUT_OF_FRAME ##1 !O_OUT_OF_FRAME;
    endsequence
    // the response is launched one cycle after both channels are seen taken
    a_write_answer: assert property (s_wr_taken |-> ##2 O_S_AXI_BVALID)
        else $error("write response did not follow the taken write");
    a_read_answer: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID)
        else $error("read data did not follow the taken address");
    a_write_busy: assert property (O_S_AXI_BVALID |-> !O_S_AXI_AWREADY && !O_S_AXI_WREADY)
        else $error("write channels ready while response pending");
    a_read_busy: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
        else $error("read address ready while data pending");
    a_no_err_oof: assert property (s_oof_held |-> !O_PM_FBIT_ERR)
        else $error("framing error event while out of frame");
    a_frame_zero: assert property (s_oof_held |-> O_FRAME_NUM == 7'h00)
        else $error("frame number nonzero while out of frame");
    a_frame_range: assert property (s_lock_held |-> O_FRAME_NUM inside {[7'h01:7'h48]})
        else $error("frame number out of range while aligned");
    a_mf_spacing: assert property (O_MF_START |=> !O_MF_START [*8])
        else $error("multiframe start repeated too soon");
    a_cofa_single: assert property (O_PM_COFA |=> !O_PM_COFA [*8])
        else $error("alignment change event repeated");
endmodule // t1_frame_monitor_assertions
bind t1_slc96_sf_frame_monitor t1_frame_monitor_assertions i_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
    .I_S_AXI_AWVALID(I_S_AXI_AWVALID), .O_S_AXI_AWREADY(O_S_AXI_AWREADY),
    .I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY),
    .O_S_AXI_BVALID(O_S_AXI_BVALID), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
    .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RVALID(O_S_AXI_RVALID),
    .O_OUT_OF_FRAME(O_OUT_OF_FRAME), .O_FRAME_NUM(O_FRAME_NUM), .O_MF_START(O_MF_START),
    .O_PM_FBIT_ERR(O_PM_FBIT_ERR), .O_PM_COFA(O_PM_COFA)
);

// >>> test/t1_line_source.sv
// behavioural remote terminal: framed sf / slc-96 line stream with fault injection
`timescale 1ns/100ps
module t1_line_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic slc,
    input wire logic slow,
    input wire logic slip,
    input wire logic [11:0] flip,
    output logic line_bit,
    output logic line_valid,
    output logic [6:0] last_fframe
);
    localparam logic [11:0] SF_SEQ = 12'h8DC; // f bits of frames 1..12, frame 1 at msb
    logic [7:0] pos;
    logic [6:0] frame;
    logic [3:0] k;
    logic gap, slip_due, fval;
    always_comb begin
        k = 4'((frame - 7'd1) % 7'd12);
        fval = SF_SEQ[4'd11 - k] ^ flip[k];
        if (slc && !frame[0] && frame >= 7'd24 && frame <= 7'd70) begin
            fval = (frame != 7'd46) && (frame != 7'd50);
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            pos <= 8'h00;
            frame <= 7'h01;
            gap <= 1'b0;
            slip_due <= 1'b0;
            line_valid <= 1'b0;
            line_bit <= 1'b0;
            last_fframe <= 7'h00;
        end else begin
            if (slip) begin
                slip_due <= 1'b1;
            end
            gap <= slow && !gap;
            line_valid <= !(slow && !gap);
            if (slow && !gap) begin
                // between bits the line shows no stale value
                line_bit <= ~line_bit;
            end else begin
                // data columns stay constant across frames, so they can never mimic alignment
                line_bit <= (pos == 8'h00) ? fval : pos[0];
                if (pos == 8'h00) begin
                    last_fframe <= frame;
                end
                if (pos == (slip_due ? 8'hC1 : 8'hC0)) begin
                    pos <= 8'h00;
                    slip_due <= 1'b0;
                    frame <= (frame == 7'h48) ? 7'h01 : frame + 7'h01;
                end else begin
                    pos <= pos + 8'h01;
                end
            end
        end
    end
endmodule // t1_line_source

// >>> test/tb.sv
// self-checking bench: line source, axi4-lite master and framing scenarios
`timescale 1ns/100ps
`include "t1_frame_monitor_regs.vh"
module tb;
    logic clk_sys, rst = 1'b1, slc = 1'b0, slow = 1'b0, slip = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic [11:0] flip = 12'h000;
    logic [6:0] last_fframe, frame_num;
    logic [1:0] bresp, rresp, rs, sig_ph;
    logic line_bit, line_valid, awready, wready, bvalid, arready, rvalid;
    logic oof, oof_q, mf, pm_err, pm_cofa, fstb, sig_bit;
    int err_total = 0, checks_done = 0, pm_cnt = 0, cofa_cnt = 0, oof_rise = 0;
    int fs_cnt = 0, sig_cnt = 0;
    t1_slc96_sf_frame_monitor i_t1_slc96_sf_frame_monitor (
        .I_CLK_SYS(clk_sys), .I_RST(rst), .I_LINE_BIT(line_bit), .I_LINE_VALID(line_valid),
        .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready),
        .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(wvalid),
        .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid),
        .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid),
        .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp),
        .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready), .O_OUT_OF_FRAME(oof),
        .O_FRAME_NUM(frame_num), .O_FBIT_STROBE(fstb), .O_MF_START(mf), .O_SIG_BIT(sig_bit),
        .O_SIG_PHASE(sig_ph), .O_PM_FBIT_ERR(pm_err), .O_PM_COFA(pm_cofa));
    t1_line_source i_t1_line_source (.clk(clk_sys), .rst(rst), .slc(slc), .slow(slow),
        .slip(slip), .flip(flip), .line_bit(line_bit), .line_valid(line_valid),
        .last_fframe(last_fframe));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        oof_q <= oof;
        if (pm_err === 1'b1) pm_cnt <= pm_cnt + 1;
        if (pm_cofa === 1'b1) cofa_cnt <= cofa_cnt + 1;
        if (fstb === 1'b1) fs_cnt <= fs_cnt + 1;
        if (sig_bit === 1'b1) sig_cnt <= sig_cnt + 1;
        if (oof === 1'b1 && oof_q === 1'b0) oof_rise <= oof_rise + 1;
    end
    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin do @(posedge clk_sys); while (awready !== 1'b1); awvalid <= 1'b0; end
            begin do @(posedge clk_sys); while (wready !== 1'b1); wvalid <= 1'b0; end
        join
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_reg(a, rd, rs);
        chk(rd & m, e);
    endtask
    task automatic wait_oof(input logic lvl, input int lim);
        int n;
        n = 0;
        while (oof !== lvl && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(oof), 32'(lvl));
    endtask
    // always moves past at least one edge so one pulse is never counted twice
    task automatic wait_mf(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (mf !== 1'b1 && n < lim);
        chk(32'(mf), 32'h1);
    endtask
    task automatic t_reset_regs();
        chk_reg(`OFS_CTRL, 32'h0000_001F, 32'h0000_0001);
        chk_reg(`OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        rd_reg(8'h10, rd, rs);
        chk(rd, 32'h0000_0000);
        chk(32'(rs), 32'(`RESP_SLVERR));
        wr(8'h10, 32'hFFFF_FFFF, rs);
        chk(32'(rs), 32'(`RESP_SLVERR));
    endtask
    task automatic t_sf_lock();
        wait_oof(1'b0, 6000);
        wait_mf(3000);
        chk(32'((last_fframe - 7'd1) % 7'd12), 32'h0000_0000);
        chk(32'(sig_ph), 32'h0000_0001);
        chk_reg(`OFS_EVENT, 32'h0000_0001, 32'h0000_0001);
        wr(`OFS_EVENT, 32'h0000_000F, rs);
        chk_reg(`OFS_EVENT, 32'h0000_000F, 32'h0000_0000);
    endtask
    task automatic t_single_err();
        int p, f, s;
        wait_mf(3000);
        p = pm_cnt;
        f = fs_cnt;
        s = sig_cnt;
        flip <= 12'h040;
        wait_mf(3000);
        flip <= 12'h000;
        chk(pm_cnt - p, 32'h0000_0001);
        chk(fs_cnt - f, 32'h0000_000C);
        chk(sig_cnt - s, 32'h0000_0030);
        chk_reg(`OFS_EVENT, 32'h0000_000E, 32'h0000_0004);
        chk_reg(`OFS_ERRCNT, 32'h0000_FFFF, 32'h0000_0001);
        chk_reg(`OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
    endtask
    task automatic t_slip_cofa();
        wr(`OFS_EVENT, 32'h0000_000F, rs);
        slip <= 1'b1;
        @(posedge clk_sys);
        slip <= 1'b0;
        wait_oof(1'b1, 8000);
        wait_oof(1'b0, 8000);
        chk(cofa_cnt, 32'h0000_0001);
        chk_reg(`OFS_EVENT, 32'h0000_0008, 32'h0000_0008);
    endtask
    task automatic t_severe();
        wr(`OFS_CTRL, 32'h0000_000C, rs);
        wr(`OFS_EVENT, 32'h0000_000F, rs);
        wait_mf(3000);
        flip <= 12'h3C0;
        wait_mf(3000);
        flip <= 12'h000;
        chk(32'(oof), 32'h0000_0000);
        chk_reg(`OFS_EVENT, 32'h0000_0006, 32'h0000_0006);
        chk_reg(`OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
    endtask
    task automatic t_manual();
        int r;
        r = oof_rise;
        slow <= 1'b1;
        wr(`OFS_CTRL, 32'h0000_0002, rs);
        wait_oof(1'b1, 20);
        wait_oof(1'b0, 12000);
        wr(`OFS_CTRL, 32'h0000_0002, rs);
        repeat (2000) @(posedge clk_sys);
        chk(oof_rise - r, 32'h0000_0001);
        chk(cofa_cnt, 32'h0000_0001);
        slow <= 1'b0;
    endtask
    task automatic t_slc();
        int p, f, s;
        slc <= 1'b1;
        wr(`OFS_CTRL, 32'h0000_0011, rs);
        wr(`OFS_CTRL, 32'h0000_0013, rs);
        wait_oof(1'b1, 20);
        wait_oof(1'b0, 25000);
        wait_mf(15000);
        chk(32'(last_fframe), 32'h0000_0001);
        chk(32'(sig_ph), 32'h0000_0003);
        p = pm_cnt;
        f = fs_cnt;
        s = sig_cnt;
        wait_mf(15000);
        chk(pm_cnt - p, 32'h0000_0000);
        chk(fs_cnt - f, 32'h0000_0048);
        chk(sig_cnt - s, 32'h0000_0120);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_regs();
        t_sf_lock();
        t_single_err();
        t_slip_cofa();
        t_severe();
        t_manual();
        t_slc();
        final_report();
    end
    // the scenarios need about 80000 cycles at most
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
endmodule // tb
